// File: logic/rssa_core.sv
// Execution datapath for rotates, subtracts, skips, bit sets and swap
// Behaviour
// - Memory rotate left via carry: old carry to bit 0, bit 7 to carry.
// - Accumulator rotate left via carry: same result to accumulator, memory kept.
// - Memory plain rotate right, bit 0 into bit 7, flags unchanged.
// - Accumulator plain rotate right of memory byte, memory and flags unchanged.
// - Memory rotate right via carry: carry to bit 7, bit 0 to carry.
// - Accumulator rotate right via carry, carry gets bit 0, memory kept.
// - Subtract with borrow: acc plus inverted memory plus carry to accumulator.
// - Subtract with borrow to memory, same flag updates.
// - Subtract memory: acc plus inverted memory plus one, to acc or memory.
// - Subtract immediate: acc plus inverted immediate plus one, all four flags.
// - Skip discards prefetched instruction with dummy cycle: two cycles, else one.
// - Decrement memory, write back, skip when zero, flags unchanged.
// - Decrement into accumulator, memory kept, skip when zero.
// - Increment memory, write back, skip when zero, flags unchanged.
// - Increment into accumulator, memory kept, skip when zero.
// - Skip when selected memory bit is one; no data or flag change.
// - Byte set writes all ones to memory, no flag change.
// - Bit set forces selected bit to one, others and flags kept.
// - Nibble swap of memory byte written back, no flag change.
`timescale 1ns/1ps
`default_nettype none
module rssa_core
    import rssa_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Instruction issue
    input wire logic issue_i,
    input wire logic [OP_W-1:0] op_i,
    input wire logic [DATA_W-1:0] mem_rd_i,
    input wire logic [DATA_W-1:0] imm_i,
    input wire logic [BIT_SEL_W-1:0] bit_sel_i,
    // Architectural state
    output logic [DATA_W-1:0] acc_o,
    output logic carry_flag_o,
    output logic zero_flag_o,
    output logic signed_wrap_flag_o,
    output logic half_carry_flag_o,
    // Memory write-back
    output logic mem_we_o,
    output logic [DATA_W-1:0] mem_wd_o,
    // Sequencing
    output logic busy_o,
    output logic discard_o
);
    ////////////////////////////////////////////////////////////////////
    function automatic logic [DATA_W-1:0] bit_mask(input logic [BIT_SEL_W-1:0] sel);
        bit_mask = ONE << sel;
    endfunction

    ////////////////////////////////////////////////////////////////////
    logic [DATA_W-1:0] add_b;
    logic add_cin;
    logic [DATA_W-1:0] add_sum;
    logic add_cout;
    logic add_half;
    logic add_ovf;

    rssa_op_type op;
    assign op = rssa_op_type'(op_i);

    always_comb begin
        add_b = ~mem_rd_i;
        add_cin = 1'b1;
        case (op)
            OP_SBC_ACC, OP_SBC_MEM: begin
                add_cin = carry_flag_o;
            end
            OP_SUB_IMM: begin
                add_b = ~imm_i;
            end
            default: begin
                add_cin = 1'b1;
            end
        endcase
    end

    rssa_adder #(.W(DATA_W)) u_adder (
        .a_i(acc_o),
        .b_i(add_b),
        .cin_i(add_cin),
        .sum_o(add_sum),
        .cout_o(add_cout),
        .half_o(add_half),
        .ovf_o(add_ovf)
    );

    ////////////////////////////////////////////////////////////////////
    logic [DATA_W-1:0] next_acc;
    logic next_carry_flag;
    logic next_zero_flag;
    logic next_signed_wrap_flag;
    logic next_half_carry_flag;
    logic next_mem_we;
    logic [DATA_W-1:0] next_mem_wd;
    logic skip;
    logic [DATA_W-1:0] dec_val;
    logic [DATA_W-1:0] inc_val;
    logic exec;
    rssa_state_type state;
    rssa_state_type next_state;

    // New instructions are taken only in the run state
    assign exec = issue_i && (state == ST_RUN);

    always_comb begin
        next_acc = acc_o;
        next_carry_flag = carry_flag_o;
        next_zero_flag = zero_flag_o;
        next_signed_wrap_flag = signed_wrap_flag_o;
        next_half_carry_flag = half_carry_flag_o;
        next_mem_we = 1'b0;
        next_mem_wd = mem_wd_o;
        skip = 1'b0;
        dec_val = mem_rd_i - ONE;
        inc_val = mem_rd_i + ONE;
        if (exec) begin
            case (op)
                OP_RLC_MEM: begin
                    next_mem_we = 1'b1;
                    next_mem_wd = {mem_rd_i[MSB-1:LSB], carry_flag_o};
                    next_carry_flag = mem_rd_i[MSB];
                end
                OP_RLC_ACC: begin
                    next_acc = {mem_rd_i[MSB-1:LSB], carry_flag_o};
                    next_carry_flag = mem_rd_i[MSB];
                end
                OP_RR_MEM: begin
                    next_mem_we = 1'b1;
                    next_mem_wd = {mem_rd_i[LSB], mem_rd_i[MSB:LSB+1]};
                end
                OP_RR_ACC: begin
                    next_acc = {mem_rd_i[LSB], mem_rd_i[MSB:LSB+1]};
                end
                OP_RRC_MEM: begin
                    next_mem_we = 1'b1;
                    next_mem_wd = {carry_flag_o, mem_rd_i[MSB:LSB+1]};
                    next_carry_flag = mem_rd_i[LSB];
                end
                OP_RRC_ACC: begin
                    next_acc = {carry_flag_o, mem_rd_i[MSB:LSB+1]};
                    next_carry_flag = mem_rd_i[LSB];
                end
                OP_SBC_ACC, OP_SUB_ACC, OP_SUB_IMM: begin
                    next_acc = add_sum;
                    next_carry_flag = add_cout;
                    next_zero_flag = (add_sum == BYTE_ZERO);
                    next_signed_wrap_flag = add_ovf;
                    next_half_carry_flag = add_half;
                end
                OP_SBC_MEM, OP_SUB_MEM: begin
                    next_mem_we = 1'b1;
                    next_mem_wd = add_sum;
                    next_carry_flag = add_cout;
                    next_zero_flag = (add_sum == BYTE_ZERO);
                    next_signed_wrap_flag = add_ovf;
                    next_half_carry_flag = add_half;
                end
                OP_DEC_SKIP: begin
                    next_mem_we = 1'b1;
                    next_mem_wd = dec_val;
                    skip = (dec_val == BYTE_ZERO);
                end
                OP_DEC_ACC_SKIP: begin
                    next_acc = dec_val;
                    skip = (dec_val == BYTE_ZERO);
                end
                OP_INC_SKIP: begin
                    next_mem_we = 1'b1;
                    next_mem_wd = inc_val;
                    skip = (inc_val == BYTE_ZERO);
                end
                OP_INC_ACC_SKIP: begin
                    next_acc = inc_val;
                    skip = (inc_val == BYTE_ZERO);
                end
                OP_BIT_SKIP: begin
                    skip = |(mem_rd_i & bit_mask(bit_sel_i));
                end
                OP_SET_BYTE: begin
                    next_mem_we = 1'b1;
                    next_mem_wd = ALL_ONES;
                end
                OP_SET_BIT: begin
                    next_mem_we = 1'b1;
                    next_mem_wd = mem_rd_i | bit_mask(bit_sel_i);
                end
                OP_SWAP_MEM: begin
                    next_mem_we = 1'b1;
                    next_mem_wd = {mem_rd_i[NIB-1:LSB], mem_rd_i[MSB:NIB]};
                end
                default: begin
                    next_mem_we = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // dummy cycle on skip
    always_comb begin
        case (state)
            ST_RUN: begin
                next_state = skip ? ST_DUMMY : ST_RUN;
            end
            ST_DUMMY: begin
                next_state = ST_RUN;
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= ST_RUN;
            acc_o <= BYTE_ZERO;
            carry_flag_o <= 1'b0;
            zero_flag_o <= 1'b0;
            signed_wrap_flag_o <= 1'b0;
            half_carry_flag_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_wd_o <= BYTE_ZERO;
            busy_o <= 1'b0;
            discard_o <= 1'b0;
        end else begin
            state <= next_state;
            acc_o <= next_acc;
            carry_flag_o <= next_carry_flag;
            zero_flag_o <= next_zero_flag;
            signed_wrap_flag_o <= next_signed_wrap_flag;
            half_carry_flag_o <= next_half_carry_flag;
            mem_we_o <= next_mem_we;
            mem_wd_o <= next_mem_wd;
            busy_o <= (next_state == ST_DUMMY);
            discard_o <= (next_state == ST_DUMMY);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    a_rlc_carry: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (exec && op == OP_RLC_MEM) |=> (carry_flag_o == $past(mem_rd_i[MSB])) && mem_we_o
        && mem_wd_o == {$past(mem_rd_i[MSB-1:LSB]), $past(carry_flag_o)})
        else $error("left rotate via carry wrong");
    a_rlc_acc: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (exec && op == OP_RLC_ACC) |=> !mem_we_o
        && acc_o == {$past(mem_rd_i[MSB-1:LSB]), $past(carry_flag_o)})
        else $error("left rotate to acc wrong");
    a_rr_flags: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (exec && op == OP_RR_MEM) |=> $stable(carry_flag_o) && $stable(zero_flag_o)
        && mem_wd_o == {$past(mem_rd_i[LSB]), $past(mem_rd_i[MSB:LSB+1])})
        else $error("plain right rotate wrong");
    a_rrc_carry: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (exec && op == OP_RRC_MEM) |=> carry_flag_o == $past(mem_rd_i[LSB]))
        else $error("right rotate carry wrong");
    a_sub_zero: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (exec && op == OP_SUB_ACC) |=> zero_flag_o == (acc_o == BYTE_ZERO)
        && acc_o == $past(acc_o - mem_rd_i))
        else $error("subtract result wrong");
    a_skip_two: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (exec && skip) |=> discard_o ##1 !discard_o)
        else $error("skip dummy cycle wrong");
    a_dec_skip: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (exec && op == OP_DEC_SKIP && mem_rd_i == ONE) |=> discard_o && mem_wd_o == BYTE_ZERO)
        else $error("decrement skip wrong");
    a_set_byte: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (exec && op == OP_SET_BYTE) |=> mem_we_o && mem_wd_o == ALL_ONES && $stable(carry_flag_o))
        else $error("byte set wrong");
    a_swap_nib: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (exec && op == OP_SWAP_MEM) |=> mem_wd_o == {$past(mem_rd_i[NIB-1:LSB]),
        $past(mem_rd_i[MSB:NIB])})
        else $error("nibble swap wrong");
    a_bit_set: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (exec && op == OP_SET_BIT) |=> mem_we_o
        && mem_wd_o == ($past(mem_rd_i) | bit_mask($past(bit_sel_i))))
        else $error("bit set wrong");
    c_skip_taken: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
        exec && skip ##1 discard_o);
    c_sbc_exec: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
        exec && op == OP_SBC_MEM);
    c_bit_skip: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
        exec && op == OP_BIT_SKIP && skip);
endmodule
`default_nettype wire

// File: logic/rssa_pkg.sv
// Shared constants and types for the rotate/subtract/skip datapath
package rssa_pkg;
    localparam int DATA_W = 8;
    localparam int BIT_SEL_W = 3;
    localparam int OP_W = 5;
    localparam int MSB = 7;
    localparam int LSB = 0;
    localparam int NIB = 4;
    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] ONE = 8'h01;
    localparam logic [1:0] SKIP_CYCLES = 2'h2;
    localparam logic [1:0] PLAIN_CYCLES = 2'h1;

    // Operation select codes
    typedef enum logic [4:0] {
        OP_NONE = 5'h00,
        OP_RLC_MEM = 5'h01,
        OP_RLC_ACC = 5'h02,
        OP_RR_MEM = 5'h03,
        OP_RR_ACC = 5'h04,
        OP_RRC_MEM = 5'h05,
        OP_RRC_ACC = 5'h06,
        OP_SBC_ACC = 5'h07,
        OP_SBC_MEM = 5'h08,
        OP_SUB_ACC = 5'h09,
        OP_SUB_MEM = 5'h0A,
        OP_SUB_IMM = 5'h0B,
        OP_DEC_SKIP = 5'h0C,
        OP_DEC_ACC_SKIP = 5'h0D,
        OP_INC_SKIP = 5'h0E,
        OP_INC_ACC_SKIP = 5'h0F,
        OP_BIT_SKIP = 5'h10,
        OP_SET_BYTE = 5'h11,
        OP_SET_BIT = 5'h12,
        OP_SWAP_MEM = 5'h13
    } rssa_op_type;

    // Sequencer states, one-hot
    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_DUMMY = 2'b10
    } rssa_state_type;
endpackage

// File: logic/rssa_adder.sv
// Eight-bit adder with carry-in producing sum and arithmetic flags
`timescale 1ns/1ps
`default_nettype none
module rssa_adder
    import rssa_pkg::*;
#(
    parameter int W = DATA_W
) (
    // Operands
    input wire logic [W-1:0] a_i,
    input wire logic [W-1:0] b_i,
    input wire logic cin_i,
    // Results
    output logic [W-1:0] sum_o,
    output logic cout_o,
    output logic half_o,
    output logic ovf_o
);
    logic [NIB:0] low;
    logic [W:0] full;
    always_comb begin
        low = {1'b0, a_i[NIB-1:0]} + {1'b0, b_i[NIB-1:0]} + {{NIB{1'b0}}, cin_i};
        full = {1'b0, a_i} + {1'b0, b_i} + {{W{1'b0}}, cin_i};
        sum_o = full[W-1:0];
        cout_o = full[W];
        half_o = low[NIB];
        // Signed overflow: like-signed operands, sum sign differs
        ovf_o = (a_i[W-1] == b_i[W-1]) && (full[W-1] != a_i[W-1]);
    end
endmodule
`default_nettype wire

// File: verif/tb.sv
// Self-checking testbench for the rotate/subtract/skip datapath
`timescale 1ns/1ps
`default_nettype none
module tb
    import rssa_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic issue_i = 1'b0;
    logic [4:0] op_i = 5'h00;
    logic [7:0] mem_rd_i = 8'h00;
    logic [7:0] imm_i = 8'h00;
    logic [2:0] bit_sel_i = 3'h0;
    logic [7:0] acc_o;
    logic [7:0] mem_wd_o;
    logic c_o, z_o, v_o, h_o, mem_we_o, busy_o, discard_o;
    logic [7:0] e_acc = 8'h00;
    logic [3:0] e_f = 4'h0;
    int err_count = 0;
    int comparisons = 0;

    rssa_core rssa_core_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .issue_i(issue_i),
        .op_i(op_i), .mem_rd_i(mem_rd_i), .imm_i(imm_i), .bit_sel_i(bit_sel_i),
        .acc_o(acc_o), .carry_flag_o(c_o), .zero_flag_o(z_o), .signed_wrap_flag_o(v_o),
        .half_carry_flag_o(h_o), .mem_we_o(mem_we_o), .mem_wd_o(mem_wd_o),
        .busy_o(busy_o), .discard_o(discard_o));

    always #20 core_clk_i = ~core_clk_i;

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Flags packed {carry, zero, wrap, half} against the model
    task automatic check_state;
        check("acc", acc_o, e_acc);
        check("flags", {4'h0, c_o, z_o, v_o, h_o}, {4'h0, e_f});
    endtask

    // One issue, then the answer cycle and the cycle after it
    task automatic do_op(input logic [4:0] op, input logic [7:0] m, input logic [7:0] imm,
            input logic [2:0] bs, input logic we, input logic [7:0] wd, input logic skip);
        @(posedge core_clk_i);
        issue_i <= 1'b1;
        op_i <= op;
        mem_rd_i <= m;
        imm_i <= imm;
        bit_sel_i <= bs;
        @(posedge core_clk_i);
        issue_i <= 1'b0;
        #1;
        check_state();
        check("mem_we", {7'h0, mem_we_o}, {7'h0, we});
        if (we) check("mem_wd", mem_wd_o, wd);
        check("skip", {6'h0, busy_o, discard_o}, {6'h0, skip, skip});
        @(posedge core_clk_i);
        #1;
        check("quiet", {5'h0, busy_o, discard_o, mem_we_o}, 8'h00);
    endtask

    // Subtract model: a + ~b + cin, flags {carry, zero, wrap, half}
    function automatic logic [11:0] sub_model(input logic [7:0] a, b, input logic cin);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
        h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
        return {s[8], s[7:0] == 8'h00, (a[7] == ~b[7]) && (s[7] != a[7]), h[4], s[7:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_rotates;
        logic [7:0] m, r;
        logic [4:0] op;
        logic nc;
        for (int k = 0; k < 2; k++) begin
            m = k ? 8'h69 : 8'h96;
            for (int i = 1; i <= 6; i++) begin
                op = i[4:0];
                case (op)
                    OP_RLC_MEM, OP_RLC_ACC: begin
                        r = {m[6:0], e_f[3]};
                        nc = m[7];
                    end
                    OP_RR_MEM, OP_RR_ACC: begin
                        r = {m[0], m[7:1]};
                        nc = e_f[3];
                    end
                    default: begin
                        r = {e_f[3], m[7:1]};
                        nc = m[0];
                    end
                endcase
                e_f[3] = nc;
                if (!op[0]) e_acc = r;
                do_op(op, m, 8'h00, 3'h0, op[0], r, 1'b0);
            end
        end
    endtask

    task automatic sub_case(input logic [4:0] op, input logic [7:0] a, b, input logic c);
        logic [11:0] res;
        logic mem;
        logic oc;
        // Model carry must be updated before the op is judged
        oc = e_f[3];
        e_f[3] = c;
        do_op(OP_RRC_MEM, {7'h00, c}, 8'h00, 3'h0, 1'b1, {oc, 7'h00}, 1'b0);
        e_acc = a;
        do_op(OP_RR_ACC, {a[6:0], a[7]}, 8'h00, 3'h0, 1'b0, 8'h00, 1'b0);
        res = sub_model(a, b, (op == OP_SBC_ACC || op == OP_SBC_MEM) ? c : 1'b1);
        mem = (op == OP_SBC_MEM || op == OP_SUB_MEM);
        e_f = res[11:8];
        if (!mem) e_acc = res[7:0];
        if (op == OP_SUB_IMM) begin
            do_op(op, ~b, b, 3'h0, 1'b0, 8'h00, 1'b0);
        end else begin
            do_op(op, b, ~b, 3'h0, mem, res[7:0], 1'b0);
        end
    endtask

    task automatic t_subtracts;
        sub_case(OP_SBC_ACC, 8'h10, 8'h01, 1'b0);
        sub_case(OP_SBC_ACC, 8'h80, 8'h01, 1'b1);
        sub_case(OP_SBC_MEM, 8'h05, 8'h05, 1'b1);
        sub_case(OP_SUB_ACC, 8'h00, 8'h01, 1'b0);
        sub_case(OP_SUB_MEM, 8'h7F, 8'hFF, 1'b0);
        sub_case(OP_SUB_IMM, 8'h33, 8'h33, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_skips;
        do_op(OP_DEC_SKIP, 8'h01, 8'h00, 3'h0, 1'b1, 8'h00, 1'b1);
        do_op(OP_DEC_SKIP, 8'h00, 8'h00, 3'h0, 1'b1, 8'hFF, 1'b0);
        e_acc = 8'h00;
        do_op(OP_DEC_ACC_SKIP, 8'h01, 8'h00, 3'h0, 1'b0, 8'h00, 1'b1);
        do_op(OP_INC_SKIP, 8'hFF, 8'h00, 3'h0, 1'b1, 8'h00, 1'b1);
        do_op(OP_INC_SKIP, 8'h7F, 8'h00, 3'h0, 1'b1, 8'h80, 1'b0);
        e_acc = 8'hFF;
        do_op(OP_INC_ACC_SKIP, 8'hFE, 8'h00, 3'h0, 1'b0, 8'h00, 1'b0);
        for (int i = 0; i < 8; i++) begin
            do_op(OP_BIT_SKIP, 8'h01 << i, 8'h00, i[2:0], 1'b0, 8'h00, 1'b1);
            do_op(OP_BIT_SKIP, ~(8'h01 << i), 8'h00, i[2:0], 1'b0, 8'h00, 1'b0);
        end
    endtask

    task automatic t_sets;
        do_op(OP_SET_BYTE, 8'h00, 8'h00, 3'h0, 1'b1, 8'hFF, 1'b0);
        for (int i = 0; i < 8; i++) begin
            do_op(OP_SET_BIT, 8'h5A, 8'h00, i[2:0], 1'b1, 8'h5A | (8'h01 << i), 1'b0);
        end
        do_op(OP_SWAP_MEM, 8'h1E, 8'h00, 3'h0, 1'b1, 8'hE1, 1'b0);
        // Unused code must leave everything alone
        do_op(5'h1F, 8'h12, 8'h34, 3'h0, 1'b0, 8'h00, 1'b0);
    endtask

    // Issue held high through the dummy cycle, then back to back
    task automatic t_refused;
        @(posedge core_clk_i);
        issue_i <= 1'b1;
        op_i <= OP_DEC_SKIP;
        mem_rd_i <= 8'h01;
        @(posedge core_clk_i);
        op_i <= OP_SET_BYTE;
        @(posedge core_clk_i);
        op_i <= OP_SET_BIT;
        mem_rd_i <= 8'h00;
        bit_sel_i <= 3'h0;
        #1;
        check("dummy", {5'h0, busy_o, discard_o, mem_we_o}, 8'h00);
        check("held_wd", mem_wd_o, 8'h00);
        @(posedge core_clk_i);
        bit_sel_i <= 3'h1;
        #1;
        check("b2b_wd0", {mem_we_o, mem_wd_o[6:0]}, 8'h81);
        @(posedge core_clk_i);
        issue_i <= 1'b0;
        #1;
        check("b2b_wd1", {mem_we_o, mem_wd_o[6:0]}, 8'h82);
        @(posedge core_clk_i);
    endtask

    task automatic t_reset;
        @(posedge core_clk_i);
        nrst_i <= 1'b0;
        @(negedge core_clk_i);
        e_acc = 8'h00;
        e_f = 4'h0;
        check_state();
        check("rst_out", {5'h0, busy_o, discard_o, mem_we_o}, 8'h00);
        repeat (2) @(posedge core_clk_i);
        nrst_i <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge core_clk_i);
        err_count++;
        close_out();
    end

    initial begin
        repeat (12) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        #1;
        check_state();
        t_rotates();
        t_subtracts();
        t_skips();
        t_sets();
        t_refused();
        t_reset();
        t_rotates();
        close_out();
    end
endmodule
`default_nettype wire
